// ---- core/pulse_counter_pkg.sv ----
// Package: constants and carrier types for the pulse counter block
// Function
// - Two independent, separately configured counter channels
// - Trigger event snapshots count for motion control
// - Selector 0 uses registers, 1 embedded program
// - Source word picks reset, capture, count, duty
// - Capture rising edge copies count to capture
// - Reset function clears count to zero
// - Latch on capture edge or period, period latch compensated
`default_nettype none
package pulse_counter_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CMD_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SRC_ONE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PER_ONE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CNT_ONE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAP_ONE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SRC_TWO = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_CMP_TWO = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_PER_TWO = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CNT_TWO = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_CAP_TWO = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_SW_CAP = 8'h30;

    // Digit values of the control and source words
    localparam logic [3:0] DIG_OFF = 4'h0;
    localparam logic [3:0] DIG_ON = 4'h1;
    localparam logic [3:0] SRC_LOW = 4'h0;
    localparam logic [3:0] SRC_HIGH = 4'h1;
    localparam logic [3:0] SRC_IN8 = 4'h2;
    localparam logic [3:0] SRC_IN7 = 4'h3;
    localparam logic [3:0] TRIG_SW = 4'h0;
    localparam logic [3:0] TRIG_IN8 = 4'h1;
    localparam logic [3:0] TRIG_IN7 = 4'h2;

    localparam logic [15:0] CMD_PARAM = 16'h0000;
    localparam logic [15:0] CMD_PLC = 16'h0001;

    localparam logic [15:0] RST_CMD_SEL = 16'h0000;
    localparam logic [15:0] RST_CTRL_ONE = 16'h0010;
    localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
    localparam logic [15:0] RST_SRC = 16'h0100;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0;

    localparam int KIND_COUNT = 0;
    localparam int KIND_TRIG = 1;

    // Digit D is the top nibble, digit A the bottom one
    typedef struct packed {
        logic [3:0] captureOn;
        logic [3:0] forward;
        logic [3:0] enable;
        logic [3:0] clear;
    } chan_ctrl_t;

    typedef struct packed {
        logic [3:0] dutyFix;
        logic [3:0] countSrc;
        logic [3:0] captureSrc;
        logic [3:0] resetSrc;
    } chan_src_t;

    typedef struct packed {
        logic lowPulse;
        logic highPulse;
        logic inSeven;
        logic inEight;
    } pins_t;

    typedef struct packed {
        chan_ctrl_t [1:0] ctrl;
        logic [1:0] capture;
    } plc_cmd_t;
endpackage
`default_nettype wire

// ---- core/input_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none
module input_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t n;

    if (W < 1) begin : g_bad_width
        $error("input_sync: width must be at least one");
    end

    // The first stage feeds only the second stage
    always_comb begin
        n.meta = pinIn;
        n.stable = s.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign pinOut = s.stable;
endmodule // input_sync
`default_nettype wire

// ---- core/source_select.sv ----
// Picks one pulse or trigger source and reports its edges
`default_nettype none
module source_select
    import pulse_counter_pkg::*;
#(
    parameter int KIND = KIND_COUNT
) (
    input wire pins_t cur,
    input wire pins_t prev,
    input wire logic [3:0] sel,
    input wire logic swEvent,
    output logic rise,
    output logic fall
);
    logic now;
    logic was;

    if (KIND != KIND_COUNT && KIND != KIND_TRIG) begin : g_bad_kind
        $error("source_select: unknown source kind");
    end

    always_comb begin
        now = 1'b0;
        was = 1'b0;
        if (KIND == KIND_COUNT) begin
            case (sel)
                SRC_LOW: begin
                    now = cur.lowPulse;
                    was = prev.lowPulse;
                end
                SRC_HIGH: begin
                    now = cur.highPulse;
                    was = prev.highPulse;
                end
                SRC_IN8: begin
                    now = cur.inEight;
                    was = prev.inEight;
                end
                SRC_IN7: begin
                    now = cur.inSeven;
                    was = prev.inSeven;
                end
                default: begin
                    now = 1'b0;
                    was = 1'b0;
                end
            endcase
        end else begin
            case (sel)
                TRIG_IN8: begin
                    now = cur.inEight;
                    was = prev.inEight;
                end
                TRIG_IN7: begin
                    now = cur.inSeven;
                    was = prev.inSeven;
                end
                default: begin
                    now = 1'b0;
                    was = 1'b0;
                end
            endcase
        end
        // Software command counts only where it is selectable
        rise = (now & ~was) |
               (KIND == KIND_TRIG && sel == TRIG_SW && swEvent);
        fall = ~now & was;
    end
endmodule // source_select
`default_nettype wire

// ---- core/pulse_counter_with_capture.sv ----
// Two-channel pulse counter with capture, behind an APB slave
`default_nettype none
module pulse_counter_with_capture
    import pulse_counter_pkg::*;
#(
    parameter int CW = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pins_t pinsAsync,
    input wire plc_cmd_t plcCmd,
    output logic [CW-1:0] countOne,
    output logic [CW-1:0] countTwo,
    output logic [CW-1:0] captureOne,
    output logic [CW-1:0] captureTwo
);
    typedef struct packed {
        logic [15:0] cmdSel;
        chan_ctrl_t [1:0] ctrl;
        chan_src_t [1:0] src;
        logic [1:0][DATA_W-1:0] per;
        logic [DATA_W-1:0] cmpTwo;
        logic [1:0] swCap;
        logic [1:0] plcCapPrev;
        pins_t prevPins;
        logic [1:0][CW-1:0] cnt;
        logic [1:0][CW-1:0] cap;
        logic [1:0][DATA_W-1:0] timer;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } top_state_t;

    top_state_t s;
    top_state_t n;

    pins_t pinsSync;
    chan_ctrl_t [1:0] ctrlEff;
    logic [1:0] capCmd;
    logic [1:0] cntRise;
    logic [1:0] cntFall;
    logic [1:0] rstRise;
    logic [1:0] rstFallUnused;
    logic [1:0] capRise;
    logic [1:0] capFallUnused;
    logic [1:0] clrEv;
    logic [1:0] stepEv;
    logic [1:0] capOn;
    logic [1:0] perOn;
    logic [1:0] perEv;
    logic [1:0] edgeCap;
    logic plcMode;
    logic acc;
    logic done;
    logic hit;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] wv;

    if (CW < 2 || CW > DATA_W) begin : g_bad_width
        $error("pulse_counter_with_capture: CW must be 2 to 32");
    end

    function automatic logic [DATA_W-1:0] mergeLanes(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Plain two-flop sampling is enough only for slow digital inputs
    input_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(pinsAsync),
        .pinOut(pinsSync)
    );

    assign plcMode = s.cmdSel == CMD_PLC;
    // Program capture is a level, so only its rising edge counts
    assign capCmd = plcMode ? (plcCmd.capture & ~s.plcCapPrev)
                            : s.swCap;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign ctrlEff[i] = plcMode ? plcCmd.ctrl[i] : s.ctrl[i];

        source_select #(.KIND(KIND_COUNT)) u_count (
            .cur(pinsSync),
            .prev(s.prevPins),
            .sel(s.src[i].countSrc),
            .swEvent(1'b0),
            .rise(cntRise[i]),
            .fall(cntFall[i])
        );
        source_select #(.KIND(KIND_TRIG)) u_reset (
            .cur(pinsSync),
            .prev(s.prevPins),
            .sel(s.src[i].resetSrc),
            .swEvent(1'b0),
            .rise(rstRise[i]),
            .fall(rstFallUnused[i])
        );
        source_select #(.KIND(KIND_TRIG)) u_capture (
            .cur(pinsSync),
            .prev(s.prevPins),
            .sel(s.src[i].captureSrc),
            .swEvent(capCmd[i]),
            .rise(capRise[i]),
            .fall(capFallUnused[i])
        );

        assign clrEv[i] = ctrlEff[i].clear == DIG_ON || rstRise[i];
        assign stepEv[i] = ctrlEff[i].enable == DIG_ON &&
            (cntRise[i] || (s.src[i].dutyFix == DIG_ON && cntFall[i]));
        assign capOn[i] = ctrlEff[i].captureOn == DIG_ON;
        assign edgeCap[i] = capOn[i] && capRise[i];
        assign perOn[i] = capOn[i] && s.per[i] != RST_WORD;
        assign perEv[i] = perOn[i] &&
            (s.timer[i] + 32'h1 >= s.per[i]);
    end

    always_comb begin
        hit = 1'b1;
        case (paddr)
            OFS_CMD_SEL: rdata = {16'h0, s.cmdSel};
            OFS_CTRL_ONE: rdata = {16'h0, s.ctrl[0]};
            OFS_SRC_ONE: rdata = {16'h0, s.src[0]};
            OFS_PER_ONE: rdata = s.per[0];
            OFS_CNT_ONE: rdata = DATA_W'($signed(s.cnt[0]));
            OFS_CAP_ONE: rdata = DATA_W'($signed(s.cap[0]));
            OFS_CTRL_TWO: rdata = {16'h0, s.ctrl[1]};
            OFS_SRC_TWO: rdata = {16'h0, s.src[1]};
            OFS_CMP_TWO: rdata = s.cmpTwo;
            OFS_PER_TWO: rdata = s.per[1];
            OFS_CNT_TWO: rdata = DATA_W'($signed(s.cnt[1]));
            OFS_CAP_TWO: rdata = DATA_W'($signed(s.cap[1]));
            OFS_SW_CAP: rdata = RST_WORD;
            default: begin
                rdata = RST_WORD;
                hit = 1'b0;
            end
        endcase
    end

    assign acc = psel && penable && !s.pready;
    assign done = psel && penable && s.pready;
    // Read-only words merge with their own value and are dropped below
    assign wv = mergeLanes(rdata, pwdata, pstrb);

    always_comb begin
        n = s;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.swCap = 2'h0;
        n.prevPins = pinsSync;
        n.plcCapPrev = plcCmd.capture;
        // One wait state keeps every bus output on a flop
        if (acc) begin
            n.pready = 1'b1;
            n.pslverr = !hit;
            n.prdata = rdata;
        end
        if (done && pwrite && hit) begin
            case (paddr)
                OFS_CMD_SEL: n.cmdSel = wv[15:0];
                OFS_CTRL_ONE: n.ctrl[0] = wv[15:0];
                OFS_SRC_ONE: n.src[0] = wv[15:0];
                OFS_PER_ONE: n.per[0] = wv;
                OFS_CTRL_TWO: n.ctrl[1] = wv[15:0];
                OFS_SRC_TWO: n.src[1] = wv[15:0];
                OFS_CMP_TWO: n.cmpTwo = wv;
                OFS_PER_TWO: n.per[1] = wv;
                OFS_SW_CAP: n.swCap = wv[1:0];
                default: n.swCap = 2'h0;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            if (clrEv[i]) begin
                n.cnt[i] = '0;
            end else if (stepEv[i]) begin
                n.cnt[i] = ctrlEff[i].forward == DIG_ON
                         ? s.cnt[i] + CW'(1)
                         : s.cnt[i] - CW'(1);
            end
            if (!perOn[i] || perEv[i]) begin
                n.timer[i] = RST_WORD;
            end else begin
                n.timer[i] = s.timer[i] + 32'h1;
            end
            // Periodic latch takes this edge's pulse so both agree
            if (edgeCap[i]) begin
                n.cap[i] = s.cnt[i];
            end else if (perEv[i]) begin
                n.cap[i] = n.cnt[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.cmdSel <= RST_CMD_SEL;
            s.ctrl[0] <= RST_CTRL_ONE;
            s.ctrl[1] <= RST_CTRL_TWO;
            s.src[0] <= RST_SRC;
            s.src[1] <= RST_SRC;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign countOne = s.cnt[0];
    assign countTwo = s.cnt[1];
    assign captureOne = s.cap[0];
    assign captureTwo = s.cap[1];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_access;
        psel && penable && !pready;
    endsequence

    sequence seq_period_end;
        perEv[1] && !edgeCap[1];
    endsequence

    sequence seq_in8_pulse;
        s.src[1].countSrc == SRC_IN8 && pinsSync.inEight &&
        !s.prevPins.inEight && ctrlEff[1].enable == DIG_ON &&
        !clrEv[1];
    endsequence

    chk_ready_after_access: assert property (
        seq_access |=> pready)
        else $error("pready did not follow the access phase");

    chk_ready_single: assert property (
        pready |=> !pready)
        else $error("pready stood longer than one cycle");

    chk_unmapped_error: assert property (
        seq_access ##0 !hit |=> pready && pslverr)
        else $error("unmapped address gave no error");

    chk_ctrl_write: assert property (
        done && pwrite && paddr == OFS_CTRL_ONE && pstrb == 4'hf
        |=> s.ctrl[0] == $past(pwdata[15:0]))
        else $error("control word write was not stored");

    chk_plc_clear: assert property (
        plcMode && plcCmd.ctrl[0].clear == DIG_ON |=> countOne == '0)
        else $error("program reset did not clear channel one");

    chk_clear_zero: assert property (
        clrEv[1] |=> countTwo == '0)
        else $error("reset did not clear channel two");

    chk_step_up: assert property (
        stepEv[0] && !clrEv[0] && ctrlEff[0].forward == DIG_ON
        |=> countOne == $past(countOne) + CW'(1))
        else $error("forward pulse did not add one");

    chk_step_down: assert property (
        stepEv[0] && !clrEv[0] && ctrlEff[0].forward == DIG_OFF
        |=> countOne == $past(countOne) - CW'(1))
        else $error("reverse pulse did not subtract one");

    chk_hold_idle: assert property (
        !stepEv[0] && !clrEv[0] |=> $stable(countOne))
        else $error("channel one moved without a pulse");

    chk_edge_capture: assert property (
        edgeCap[0] |=> captureOne == $past(countOne))
        else $error("capture edge did not copy the count");

    chk_capture_closed: assert property (
        ctrlEff[0].captureOn != DIG_ON |=> $stable(captureOne))
        else $error("capture changed while closed");

    chk_period_latch: assert property (
        seq_period_end |=> captureTwo == countTwo)
        else $error("periodic latch left count and capture apart");

    chk_src_in8: assert property (
        seq_in8_pulse |=> countTwo != $past(countTwo))
        else $error("input eight pulse was not counted");
endmodule // pulse_counter_with_capture
`default_nettype wire

// ---- testbench/pulse_source_model.sv ----
// Behavioural far side: pulse generators and digital trigger inputs
`default_nettype none
module pulse_source_model
    import pulse_counter_pkg::*;
#(
    parameter int FAST_HOLD = 4,
    parameter int DIG_HOLD = 8334
) (
    input wire logic clk_sys,
    output var pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins = '0;

    // Lines 0 and 1 are the digital inputs; a full period of 2*DIG_HOLD+1
    // cycles keeps them just under 3 kHz at 50 MHz
    task automatic pulse(input int line, input int n);
        int hold;
        hold = (line < 2) ? DIG_HOLD : FAST_HOLD;
        repeat (n) begin
            @(posedge clk_sys);
            pins[line] <= 1'b1;
            repeat (hold) @(posedge clk_sys);
            pins[line] <= 1'b0;
            repeat (hold) @(posedge clk_sys);
        end
    endtask
endmodule // pulse_source_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the two-channel pulse counter
`default_nettype none
module testbench
    import pulse_counter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LN_IN8 = 0;
    localparam int LN_IN7 = 1;
    localparam int LN_HIGH = 2;
    localparam int LN_LOW = 3;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pins_t pinsAsync;
    plc_cmd_t plcCmd = '0;
    logic [31:0] countOne, countTwo, captureOne, captureTwo;
    int nErrors = 0;
    int checkCount = 0;

    always #10 clk_sys = ~clk_sys;

    pulse_counter_with_capture uut (.clk_sys(clk_sys), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinsAsync(pinsAsync), .plcCmd(plcCmd),
        .countOne(countOne), .countTwo(countTwo),
        .captureOne(captureOne), .captureTwo(captureTwo));
    pulse_source_model partner (.clk_sys(clk_sys), .pins(pinsAsync));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= addr;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, rd, err);
        check(err, 1'b0);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        check(rd, exp);
        check(err, 1'b0);
    endtask

    // Covers the two-flop sync plus edge detect with margin
    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic test_reset();
        logic [31:0] rd;
        logic err;
        rdchk(OFS_CMD_SEL, {16'h0, RST_CMD_SEL});
        rdchk(OFS_CTRL_ONE, {16'h0, RST_CTRL_ONE});
        rdchk(OFS_CTRL_TWO, {16'h0, RST_CTRL_TWO});
        rdchk(OFS_SRC_TWO, {16'h0, RST_SRC});
        rdchk(OFS_SRC_ONE, {16'h0, RST_SRC});
        rdchk(OFS_CAP_ONE, RST_WORD);
        wr(OFS_CMP_TWO, 32'h1234abcd);
        rdchk(OFS_CMP_TWO, 32'h1234abcd);
        // Only the lowest lane may change under a partial strobe
        pstrb <= 4'h1;
        wr(OFS_CMP_TWO, 32'h000000ff);
        pstrb <= 4'hf;
        rdchk(OFS_CMP_TWO, 32'h1234abff);
        apb(1'b0, 8'hfc, 32'h0, rd, err);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test_reset done");
    endtask

    task automatic test_count();
        wr(OFS_CTRL_TWO, 32'h00000110);
        partner.pulse(LN_HIGH, 5);
        settle();
        check(countTwo, 32'h00000005);
        check(countOne, 32'hfffffffb);
        wr(OFS_CNT_TWO, 32'h00000077);
        rdchk(OFS_CNT_TWO, 32'h00000005);
        $display("test_count done");
    endtask

    task automatic test_sw_capture();
        wr(OFS_CTRL_TWO, 32'h00001110);
        wr(OFS_SW_CAP, 32'h00000003);
        settle();
        check(captureTwo, 32'h00000005);
        check(captureOne, 32'h00000000);
        rdchk(OFS_CAP_TWO, 32'h00000005);
        // Channel one alone: capture open, still enabled and reverse
        wr(OFS_CTRL_ONE, 32'h00001010);
        wr(OFS_SW_CAP, 32'h00000001);
        settle();
        check(captureOne, 32'hfffffffb);
        check(captureTwo, 32'h00000005);
        $display("test_sw_capture done");
    endtask

    task automatic test_clear();
        wr(OFS_CTRL_TWO, 32'h00001111);
        partner.pulse(LN_HIGH, 2);
        settle();
        check(countTwo, 32'h00000000);
        check(countOne, 32'hfffffff9);
        wr(OFS_CTRL_TWO, 32'h00001110);
        $display("test_clear done");
    endtask

    task automatic test_low_duty();
        wr(OFS_SRC_ONE, 32'h00000000);
        wr(OFS_CTRL_ONE, 32'h00000110);
        partner.pulse(LN_LOW, 3);
        settle();
        check(countOne, 32'hfffffffc);
        wr(OFS_SRC_ONE, 32'h00001000);
        partner.pulse(LN_LOW, 2);
        settle();
        check(countOne, 32'h00000000);
        check(countTwo, 32'h00000000);
        $display("test_low_duty done");
    endtask

    // Slow: each digital pulse respects the 3 kHz ceiling
    task automatic test_digital();
        // Count seven, capture and reset eight: capture sees the old count
        wr(OFS_SRC_TWO, 32'h00000311);
        partner.pulse(LN_IN7, 1);
        settle();
        check(countTwo, 32'h00000001);
        partner.pulse(LN_IN8, 1);
        settle();
        check(captureTwo, 32'h00000001);
        check(countTwo, 32'h00000000);
        // Reverse, count eight, capture and reset seven
        wr(OFS_CTRL_TWO, 32'h00001010);
        wr(OFS_SRC_TWO, 32'h00000222);
        partner.pulse(LN_IN8, 1);
        settle();
        check(countTwo, 32'hffffffff);
        partner.pulse(LN_IN7, 1);
        settle();
        check(captureTwo, 32'hffffffff);
        check(countTwo, 32'h00000000);
        wr(OFS_CTRL_TWO, 32'h00001110);
        $display("test_digital done");
    endtask

    task automatic test_plc();
        wr(OFS_SRC_TWO, 32'h00000100);
        @(posedge clk_sys);
        plcCmd.ctrl[1] <= 16'h1110;
        // Program says reverse while the register says forward
        plcCmd.ctrl[0] <= 16'h0010;
        wr(OFS_CMD_SEL, {16'h0, CMD_PLC});
        partner.pulse(LN_HIGH, 3);
        partner.pulse(LN_LOW, 1);
        settle();
        check(countTwo, 32'h00000003);
        check(countOne, 32'hfffffffe);
        @(posedge clk_sys);
        plcCmd.capture <= 2'b10;
        settle();
        check(captureTwo, 32'h00000003);
        plcCmd.capture <= 2'b00;
        plcCmd.ctrl[0] <= 16'h0011;
        settle();
        check(countOne, 32'h00000000);
        wr(OFS_CMD_SEL, {16'h0, CMD_PARAM});
        $display("test_plc done");
    endtask

    task automatic test_period();
        wr(OFS_PER_TWO, 32'd10);
        partner.pulse(LN_HIGH, 2);
        repeat (25) @(posedge clk_sys);
        check(captureTwo, 32'h00000005);
        check(countTwo, 32'h00000005);
        wr(OFS_PER_TWO, 32'd0);
        $display("test_period done");
    endtask

    task automatic test_rerun();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(countTwo, 32'h00000000);
        check(captureTwo, 32'h00000000);
        rdchk(OFS_CTRL_TWO, {16'h0, RST_CTRL_TWO});
        $display("test_rerun done");
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // About 67k cycles of traffic expected; the margin covers stalls
    initial begin
        repeat (100000) @(posedge clk_sys);
        nErrors++;
        $display("Watchdog expired");
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset();
        test_count();
        test_sw_capture();
        test_clear();
        test_low_duty();
        test_digital();
        test_plc();
        test_period();
        test_rerun();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
